// ### hw/bsrp_device.sv
// Functional notes
// - Master starts write: start, address, write bit
// - Acknowledge address only on own match
// - Pointer byte latched and acknowledged
// - Data byte stored at pointer, acknowledged
// - Pointer advances after each written byte
// - Master ends write with stop
// - Read: repeated start, address, read bit
// - Selected register shifted out MSB first
// - Master ack advances pointer, next byte sent
// - Master nack then stop; device releases
// - Address pin selects 58H or 5AH
// - Stray data edge abandons the transaction
// - Status read clears flags, releases fault
//
// Implementation choice: the Wishbone interface to the registers.
`default_nettype none
`include "bsrp_consts.svh"
module bsrp_device
  import bsrp_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Serial link
  bsrp_link_if.slave link,
  // Straps and events from the analog side
  input wire logic addr_sel_i,
  input wire logic [7:0] fault_evt_i,
  input wire logic [7:0] led_fault_evt_i,
  input wire logic [7:0] light_level_i,
  input wire logic [7:0] light_level_lo_i,
  input wire logic [7:0] temp_hi_i,
  input wire logic [7:0] temp_lo_i,
  // Register outputs to the analog side
  output logic [7:0] primary_brightness_o,
  output logic [7:0] primary_control_o,
  output logic [7:0] sink_enable_o,
  output logic [7:0] primary_current_o,
  output logic [7:0] secondary_current_o,
  output logic [7:0] boost_setting_o,
  output logic [7:0] secondary_brightness_o,
  output logic [7:0] light_sensor_control_o,
  output logic [7:0] nv_memory_control_o,
  output logic fault_n_o
);
  typedef struct packed {
    bsrp_slv_state_t st;
    logic [1:0] sel_m;
    logic sel;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic ack_phase;
    logic sda_low;
    logic rd_dir;
    logic [7:0] ptr;
    logic [7:0] pbright;
    logic [7:0] pctrl;
    logic [7:0] fstat;
    logic [7:0] sink;
    logic [7:0] pcur;
    logic [7:0] scur;
    logic [7:0] boost;
    logic [7:0] sbright;
    logic [7:0] lsctl;
    logic [7:0] lfault;
    logic [7:0] nvctl;
    logic fault_n;
  } bsrp_dev_t;
  bsrp_dev_t q, d;
  logic scl, sda, rise, fall, start, stop;
  ////////////////////////////////////////////////////////////////////////////
  // Line conditioning
  bsrp_line_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .scl_i(link.scl),
    .sda_i(link.sda),
    .scl_o(scl),
    .sda_o(sda),
    .scl_rise_o(rise),
    .scl_fall_o(fall),
    .start_o(start),
    .stop_o(stop)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Register read mux
  function automatic logic [7:0] rd_reg(input bsrp_dev_t s, input logic [7:0] a);
    unique case (a)
      `BSRP_REG_PBRIGHT: rd_reg = s.pbright;
      `BSRP_REG_PCTRL: rd_reg = s.pctrl;
      `BSRP_REG_FSTAT: rd_reg = s.fstat;
      `BSRP_REG_IDENT: rd_reg = `BSRP_IDENT_VAL;
      `BSRP_REG_SINK: rd_reg = s.sink;
      `BSRP_REG_PCUR: rd_reg = s.pcur;
      `BSRP_REG_SCUR: rd_reg = s.scur;
      `BSRP_REG_BOOST: rd_reg = s.boost;
      `BSRP_REG_SBRIGHT: rd_reg = s.sbright;
      `BSRP_REG_LSCTL: rd_reg = s.lsctl;
      `BSRP_REG_LLH: rd_reg = light_level_i;
      `BSRP_REG_LLL: rd_reg = light_level_lo_i;
      `BSRP_REG_LFAULT: rd_reg = s.lfault;
      `BSRP_REG_TEMPH: rd_reg = temp_hi_i;
      `BSRP_REG_TEMPL: rd_reg = temp_lo_i;
      `BSRP_REG_NVCTL: rd_reg = s.nvctl;
      default: rd_reg = `BSRP_RST_ZERO;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // Protocol engine
  always_comb begin
    logic [7:0] rbyte;
    logic clr_stat;
    logic clr_led;
    rbyte = `BSRP_RST_ZERO;
    clr_stat = 1'b0;
    clr_led = 1'b0;
    d = q;
    d.sel_m = {q.sel_m[0], addr_sel_i};
    d.sel = q.sel_m[1];
    if (fall && !q.ack_phase && q.cnt == 4'h8) begin
      // Ninth clock begins: decide acknowledge
      d.ack_phase = 1'b1;
      d.cnt = 4'h0;
      unique case (q.st)
        BSRP_S_ADDR: begin
          if (q.sh[7:1] == (q.sel ? `BSRP_ADDR_SEL1 : `BSRP_ADDR_SEL0)) begin
            d.sda_low = 1'b1;
            d.rd_dir = q.sh[0];
          end else begin
            d.st = BSRP_S_IGN;
          end
        end
        BSRP_S_PTR: begin
          d.ptr = q.sh;
          d.sda_low = 1'b1;
        end
        BSRP_S_WDAT: begin
          d.sda_low = 1'b1;
          unique case (q.ptr)
            `BSRP_REG_PBRIGHT: d.pbright = q.sh;
            `BSRP_REG_PCTRL: d.pctrl = q.sh;
            `BSRP_REG_SINK: d.sink = q.sh;
            `BSRP_REG_PCUR: d.pcur = q.sh;
            `BSRP_REG_SCUR: d.scur = q.sh;
            `BSRP_REG_BOOST: d.boost = q.sh;
            `BSRP_REG_SBRIGHT: d.sbright = q.sh;
            `BSRP_REG_LSCTL: d.lsctl = q.sh;
            `BSRP_REG_NVCTL: d.nvctl = q.sh;
            default: d.nvctl = q.nvctl; // Unmapped or read-only: dropped
          endcase
          d.ptr = q.ptr + 8'h01;
        end
        BSRP_S_RDAT: begin
          d.sda_low = 1'b0; // Release for master's answer
          d.st = BSRP_S_RACK;
        end
        default: d.st = q.st;
      endcase
    end else if (fall && q.ack_phase) begin
      // Ninth clock ends
      d.ack_phase = 1'b0;
      d.sda_low = 1'b0;
      if (q.st == BSRP_S_ADDR) begin
        d.st = q.rd_dir ? BSRP_S_RDAT : BSRP_S_PTR;
      end else if (q.st == BSRP_S_PTR) begin
        d.st = BSRP_S_WDAT;
      end
      if (d.st == BSRP_S_RDAT) begin
        rbyte = rd_reg(q, q.ptr);
        clr_stat = (q.ptr == `BSRP_REG_FSTAT);
        clr_led = (q.ptr == `BSRP_REG_LFAULT);
        d.sh = rbyte;
        d.sda_low = !rbyte[7];
      end
    end else if (fall && q.st == BSRP_S_RDAT) begin
      d.sh = {q.sh[6:0], 1'b0}; // MSB first
      d.sda_low = !q.sh[6] && (q.cnt != 4'h8);
    end
    // The master's answer is sampled in the ninth clock, while ack_phase is still set
    if (rise && q.st == BSRP_S_RACK) begin
      if (sda) begin
        d.st = BSRP_S_IGN; // Nack ends read, line stays free
      end else begin
        d.st = BSRP_S_RDAT;
        d.ptr = q.ptr + 8'h01;
        d.ack_phase = 1'b1;
      end
    end else if (rise && !q.ack_phase && q.st != BSRP_S_IDLE && q.st != BSRP_S_IGN) begin
      d.sh = (q.st == BSRP_S_RDAT) ? q.sh : {q.sh[6:0], sda};
      d.cnt = q.cnt + 4'h1;
    end
    // Sticky fault flags; new events win over a read clear
    d.fstat = (clr_stat ? `BSRP_RST_ZERO : q.fstat) | fault_evt_i;
    d.lfault = (clr_led ? `BSRP_RST_ZERO : q.lfault) | led_fault_evt_i;
    if (clr_stat) begin
      d.fault_n = 1'b1;
    end
    if (|fault_evt_i || |led_fault_evt_i) begin
      d.fault_n = 1'b0;
    end
    // Start or repeated start restarts addressing; stop or stray edge aborts
    if (start) begin
      d.st = BSRP_S_ADDR;
      d.cnt = 4'h0;
      d.ack_phase = 1'b0;
      d.sda_low = 1'b0;
    end else if (stop) begin
      d.st = BSRP_S_IDLE;
      d.sda_low = 1'b0;
      d.ack_phase = 1'b0;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.st <= BSRP_S_IDLE;
      q.pbright <= `BSRP_RST_PBRIGHT;
      q.boost <= `BSRP_RST_BOOST;
      q.fault_n <= 1'b1;
      q.sel_m <= 2'b00;
    end else begin
      q <= d;
    end
  end
  // Open-drain: enable only to pull low
  assign link.sda_s_o = 1'b0;
  assign link.sda_s_oe = q.sda_low;
  assign primary_brightness_o = q.pbright;
  assign primary_control_o = q.pctrl;
  assign sink_enable_o = q.sink;
  assign primary_current_o = q.pcur;
  assign secondary_current_o = q.scur;
  assign boost_setting_o = q.boost;
  assign secondary_brightness_o = q.sbright;
  assign light_sensor_control_o = q.lsctl;
  assign nv_memory_control_o = q.nvctl;
  assign fault_n_o = q.fault_n;
endmodule : bsrp_device
`default_nettype wire

// ### hw/bsrp_consts.svh
`ifndef BSRP_CONSTS_SVH
`define BSRP_CONSTS_SVH
// Bus address bases (7-bit) selected by the address-select pin
`define BSRP_ADDR_SEL0 7'h2C
`define BSRP_ADDR_SEL1 7'h2D
// Register pointers
`define BSRP_REG_PBRIGHT 8'h00
`define BSRP_REG_PCTRL 8'h01
`define BSRP_REG_FSTAT 8'h02
`define BSRP_REG_IDENT 8'h03
`define BSRP_REG_SINK 8'h04
`define BSRP_REG_PCUR 8'h05
`define BSRP_REG_SCUR 8'h06
`define BSRP_REG_BOOST 8'h07
`define BSRP_REG_SBRIGHT 8'h08
`define BSRP_REG_LSCTL 8'h09
`define BSRP_REG_LLH 8'h0A
`define BSRP_REG_LLL 8'h0B
`define BSRP_REG_LFAULT 8'h0C
`define BSRP_REG_TEMPH 8'h0D
`define BSRP_REG_TEMPL 8'h0E
`define BSRP_REG_NVCTL 8'h72
// Reset values
`define BSRP_RST_PBRIGHT 8'hFF
`define BSRP_RST_BOOST 8'h60
`define BSRP_RST_ZERO 8'h00
// Arbitrary identity value, not tied to any product
`define BSRP_IDENT_VAL 8'hA5
// Host wishbone register offsets (byte addresses)
`define BSRP_WB_CMD 4'h0
`define BSRP_WB_DATA 4'h4
`define BSRP_WB_STAT 4'h8
`define BSRP_WB_MASK 4'hC
// Command word fields
`define BSRP_CMD_GO 16
`define BSRP_CMD_RD 17
`define BSRP_CMD_SEL 18
// Host status bits
`define BSRP_ST_DONE 0
`define BSRP_ST_NACK 1
`define BSRP_ST_BUSY 2
// Link clock divider half period in clk_i cycles
`define BSRP_HALF_DIV 8'h08
`endif

// ### hw/bsrp_pkg.sv
`default_nettype none
package bsrp_pkg;
  typedef enum logic [6:0] {
    BSRP_S_IDLE = 7'h01,
    BSRP_S_ADDR = 7'h02,
    BSRP_S_PTR = 7'h04,
    BSRP_S_WDAT = 7'h08,
    BSRP_S_RDAT = 7'h10,
    BSRP_S_RACK = 7'h20,
    BSRP_S_IGN = 7'h40
  } bsrp_slv_state_t;
  typedef enum logic [7:0] {
    BSRP_M_IDLE = 8'h01,
    BSRP_M_START = 8'h02,
    BSRP_M_BIT = 8'h04,
    BSRP_M_ACK = 8'h08,
    BSRP_M_RSTART = 8'h10,
    BSRP_M_RBIT = 8'h20,
    BSRP_M_MACK = 8'h40,
    BSRP_M_STOP = 8'h80
  } bsrp_mst_state_t;
endpackage : bsrp_pkg
`default_nettype wire

// ### hw/bsrp_link_if.sv
`default_nettype none
interface bsrp_link_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  // Wired-AND with pull-ups: low whenever any enabled driver pulls low
  logic scl;
  logic sda;
  assign scl = !(scl_oe && !scl_o);
  assign sda = !(sda_m_oe && !sda_m_o) && !(sda_s_oe && !sda_s_o);
  modport master (output scl_o, output scl_oe, output sda_m_o, output sda_m_oe, input scl, input sda);
  modport slave (output sda_s_o, output sda_s_oe, input scl, input sda);
endinterface : bsrp_link_if
`default_nettype wire

// ### hw/bsrp_line_sync.sv
`default_nettype none
// Two-stage synchroniser plus edge and start/stop detection for both lines
module bsrp_line_sync
  import bsrp_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Raw lines
  input wire logic scl_i,
  input wire logic sda_i,
  // Filtered lines and events
  output logic scl_o,
  output logic sda_o,
  output logic scl_rise_o,
  output logic scl_fall_o,
  output logic start_o,
  output logic stop_o
);
  typedef struct packed {
    logic [1:0] scl_m;
    logic [1:0] sda_m;
    logic scl;
    logic sda;
  } bsrp_sync_t;
  bsrp_sync_t q, d;
  // Shift; only stage two and the registered copy feed logic
  always_comb begin
    d = q;
    d.scl_m = {q.scl_m[0], scl_i};
    d.sda_m = {q.sda_m[0], sda_i};
    d.scl = q.scl_m[1];
    d.sda = q.sda_m[1];
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '1;
    end else begin
      q <= d;
    end
  end
  assign scl_o = q.scl;
  assign sda_o = q.sda;
  assign scl_rise_o = q.scl_m[1] && !q.scl;
  assign scl_fall_o = !q.scl_m[1] && q.scl;
  // Data edge while clock stays high marks start or stop
  assign start_o = q.scl && q.scl_m[1] && q.sda && !q.sda_m[1];
  assign stop_o = q.scl && q.scl_m[1] && !q.sda && q.sda_m[1];
endmodule : bsrp_line_sync
`default_nettype wire

// ### hw/bsrp_host.sv
`default_nettype none
`include "bsrp_consts.svh"
// Wishbone-driven master: one register access per command
module bsrp_host
  import bsrp_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  // Serial link
  bsrp_link_if.master link
);
  typedef struct packed {
    bsrp_mst_state_t st;
    logic [7:0] div;
    logic phase;
    logic [3:0] bitn;
    logic [1:0] byten;
    logic [8:0] sh;
    logic [7:0] ptr;
    logic [7:0] wdat;
    logic [7:0] rdat;
    logic rd;
    logic asel;
    logic scl;
    logic sda;
    logic [1:0] stat;
    logic [1:0] mask;
    logic ack;
    logic [31:0] dout;
    logic irq;
    logic [1:0] sda_m;
  } bsrp_host_t;
  bsrp_host_t q, d;
  function automatic logic [7:0] addr_byte(input logic sel, input logic rd);
    addr_byte = {(sel ? `BSRP_ADDR_SEL1 : `BSRP_ADDR_SEL0), rd};
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // Bus slave, command engine and bit sequencer
  always_comb begin
    logic tick;
    logic [1:0] evt;
    d = q;
    evt = 2'b00;
    d.ack = 1'b0;
    d.sda_m = {q.sda_m[0], link.sda};
    d.div = q.div + 8'h01;
    tick = (q.div == `BSRP_HALF_DIV - 8'h01);
    if (tick) begin
      d.div = 8'h00;
    end
    if (wb_cyc_i && wb_stb_i && !q.ack) begin
      d.ack = 1'b1;
      d.dout = 32'h0000_0000;
      unique case (wb_adr_i)
        `BSRP_WB_CMD: d.dout = {13'h0000, q.asel, q.rd, q.st != BSRP_M_IDLE, q.ptr, q.wdat};
        `BSRP_WB_DATA: d.dout = {24'h00_0000, q.rdat};
        `BSRP_WB_STAT: d.dout = {29'h0000_0000, q.st != BSRP_M_IDLE, q.stat};
        `BSRP_WB_MASK: d.dout = {30'h0000_0000, q.mask};
        default: d.dout = 32'h0000_0000;
      endcase
      if (wb_we_i && wb_sel_i[0]) begin
        if (wb_adr_i == `BSRP_WB_CMD && q.st == BSRP_M_IDLE && wb_dat_i[`BSRP_CMD_GO]) begin
          d.wdat = wb_dat_i[7:0];
          d.ptr = wb_dat_i[15:8];
          d.rd = wb_dat_i[`BSRP_CMD_RD];
          d.asel = wb_dat_i[`BSRP_CMD_SEL];
          d.st = BSRP_M_START;
          d.phase = 1'b0;
          d.div = 8'h00;
        end
        if (wb_adr_i == `BSRP_WB_STAT) begin
          d.stat = q.stat & ~wb_dat_i[1:0];
        end
        if (wb_adr_i == `BSRP_WB_MASK) begin
          d.mask = wb_dat_i[1:0];
        end
      end
    end
    if (tick && q.st != BSRP_M_IDLE) begin
      d.phase = !q.phase;
      unique case (q.st)
        BSRP_M_START: begin
          // Phase 0: both high; phase 1: pull data low with clock high
          if (!q.phase) begin
            d.scl = 1'b1;
            d.sda = 1'b1;
          end else begin
            d.sda = 1'b0;
            d.st = BSRP_M_BIT;
            d.sh = {addr_byte(q.asel, 1'b0), 1'b1};
            d.bitn = 4'h0;
            d.byten = 2'b00;
          end
        end
        BSRP_M_BIT, BSRP_M_RBIT: begin
          if (!q.phase) begin
            d.scl = 1'b0;
            d.sda = (q.st == BSRP_M_RBIT) ? 1'b1 : q.sh[8]; // MSB first; a read ends in nack
          end else begin
            d.scl = 1'b1;
            if (q.bitn == 4'h8) begin
              d.st = BSRP_M_ACK;
            end else begin
              d.sh = {q.sh[7:0], q.sda_m[1]};
              d.bitn = q.bitn + 4'h1;
            end
          end
        end
        BSRP_M_ACK: begin
          if (q.sda_m[1] && q.st == BSRP_M_ACK && q.rd && q.byten == 2'b10) begin
            d.rdat = q.sh[7:0];
          end
          d.phase = 1'b0;
          d.scl = 1'b0;
          d.bitn = 4'h0;
          if (q.rd && q.byten == 2'b10) begin
            d.rdat = q.sh[7:0];
            d.st = BSRP_M_STOP; // Nack sent, now stop
          end else if (q.sda_m[1]) begin
            evt[1] = 1'b1; // Not acknowledged
            d.st = BSRP_M_STOP;
          end else if (q.byten == 2'b00) begin
            d.byten = 2'b01;
            d.sh = {q.ptr, 1'b1};
            d.st = BSRP_M_BIT;
          end else if (q.byten == 2'b01 && q.rd) begin
            d.st = BSRP_M_RSTART;
          end else if (q.byten == 2'b01) begin
            d.byten = 2'b11;
            d.sh = {q.wdat, 1'b1};
            d.st = BSRP_M_BIT;
          end else if (q.byten == 2'b11 && !q.rd) begin
            d.st = BSRP_M_STOP;
          end else begin
            // Read-direction address acknowledged: fetch the data byte
            d.st = BSRP_M_RBIT;
            d.byten = 2'b10;
          end
        end
        BSRP_M_RSTART: begin
          if (!q.phase) begin
            d.sda = 1'b1;
          end else if (!q.scl) begin
            d.scl = 1'b1;
            d.phase = 1'b0;
          end else begin
            d.sda = 1'b0;
            d.st = BSRP_M_BIT;
            d.byten = 2'b11;
            d.rd = 1'b1;
            d.sh = {addr_byte(q.asel, 1'b1), 1'b1};
          end
        end
        BSRP_M_STOP: begin
          if (!q.phase) begin
            d.sda = 1'b0;
          end else if (!q.scl) begin
            d.scl = 1'b1;
            d.phase = 1'b0;
          end else begin
            d.sda = 1'b1;
            d.st = BSRP_M_IDLE;
            evt[0] = 1'b1;
          end
        end
        default: d.st = BSRP_M_IDLE;
      endcase
    end
    d.stat = d.stat | evt; // Events win over clear
    d.irq = |(d.stat & q.mask);
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.st <= BSRP_M_IDLE;
      q.scl <= 1'b1;
      q.sda <= 1'b1;
      q.sda_m <= 2'b11;
    end else begin
      q <= d;
    end
  end
  assign wb_dat_o = q.dout;
  assign wb_ack_o = q.ack;
  assign irq_o = q.irq;
  assign link.scl_o = q.scl;
  assign link.scl_oe = !q.scl;
  assign link.sda_m_o = q.sda;
  assign link.sda_m_oe = !q.sda;
endmodule : bsrp_host
`default_nettype wire

// ### tb/bsrp_link_assertions.sv
`default_nettype none
// Watches the shared two-wire link between host and device
module bsrp_link_assertions (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link drivers and resolved lines
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  //////////////////////////////////////////////////////////////////////////////
  // Device output is open drain: it may only pull low
  a_sda_open_drain: assert property (sda_s_oe |-> !sda_s_o)
    else $error("device drove data line high");
  // Device changes its data drive only while the clock is low, so it never fakes a start or stop
  a_slave_change_low: assert property ($changed(sda_s_oe) |-> !scl && !$past(scl))
    else $error("device data drive changed with clock high");
  // A start or repeated start finds the device released
  a_start_released: assert property ($fell(sda) && scl && $past(scl) |-> !sda_s_oe)
    else $error("device driving during start");
  // After a stop the device stays off the line for at least eight cycles
  a_stop_released: assert property ($rose(sda) && scl && $past(scl) |-> !sda_s_oe [*8])
    else $error("device drove data after stop");
  // While the device drives a bit, the host keeps the line released during clock high
  a_no_contention: assert property (sda_s_oe && scl |-> !(sda_m_oe && !sda_m_o))
    else $error("host pulled data while device owned the bit");
  // Device drive never outlives 200 cycles, some twelve and a half clock pulses
  a_slave_drive_bound: assert property ($rose(sda_s_oe) |-> ##[1:200] !sda_s_oe)
    else $error("device held data line too long");
  // Clock low phase lasts at least the divider half period
  a_scl_low_min: assert property ($fell(scl) |-> !scl [*8])
    else $error("clock low phase too short");
  // Clock high phase lasts at least the divider half period
  a_scl_high_min: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
endmodule // bsrp_link_assertions
`default_nettype wire

// ### tb/bsrp_tb.sv
`default_nettype none
`include "bsrp_consts.svh"
module bsrp_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, irq_o, fault_n_o;
  logic addr_sel_i = 1'b0;
  logic [7:0] fault_evt_i = 8'h00, led_fault_evt_i = 8'h00, ll_hi = 8'h00, ll_lo = 8'h00, t_hi = 8'h00, t_lo = 8'h00;
  logic [7:0] o_pb, o_pc, o_se, o_pcur, o_scur, o_bst, o_sb, o_ls, o_nv;
  logic [15:0] lfsr_q = 16'h0004;
  logic msk_on = 1'b0;
  int num_errors = 0;
  int tests_run = 0;
  int cyc_cnt = 0;
  int mdl [256];
  logic [7:0] rw_list [8] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09};
  //////////////////////////////////////////////////////////////////////////////
  // Both ends joined on one link, checker beside it
  bsrp_link_if bsrp_link_if_inst ();
  bsrp_host bsrp_host_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .irq_o(irq_o), .link(bsrp_link_if_inst.master));
  bsrp_device bsrp_device_inst (.clk_i(clk_i), .rst_i(rst_i), .link(bsrp_link_if_inst.slave),
    .addr_sel_i(addr_sel_i), .fault_evt_i(fault_evt_i), .led_fault_evt_i(led_fault_evt_i),
    .light_level_i(ll_hi), .light_level_lo_i(ll_lo), .temp_hi_i(t_hi), .temp_lo_i(t_lo),
    .primary_brightness_o(o_pb), .primary_control_o(o_pc), .sink_enable_o(o_se), .primary_current_o(o_pcur),
    .secondary_current_o(o_scur), .boost_setting_o(o_bst), .secondary_brightness_o(o_sb),
    .light_sensor_control_o(o_ls), .nv_memory_control_o(o_nv), .fault_n_o(fault_n_o));
  bsrp_link_assertions bsrp_link_assertions_inst (.clk_i(clk_i), .rst_i(rst_i),
    .sda_s_o(bsrp_link_if_inst.sda_s_o), .sda_s_oe(bsrp_link_if_inst.sda_s_oe),
    .sda_m_o(bsrp_link_if_inst.sda_m_o), .sda_m_oe(bsrp_link_if_inst.sda_m_oe),
    .scl(bsrp_link_if_inst.scl), .sda(bsrp_link_if_inst.sda));
  //////////////////////////////////////////////////////////////////////////////
  // Clock, and a ceiling well above the expected run of some 30000 cycles
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 80000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic rnd(output logic [7:0] v);
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    v = lfsr_q[7:0];
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [7:0] port_of(input logic [7:0] p);
    case (p)
      8'h00: return o_pb;
      8'h01: return o_pc;
      8'h04: return o_se;
      8'h05: return o_pcur;
      8'h06: return o_scur;
      8'h07: return o_bst;
      8'h08: return o_sb;
      default: return o_ls;
    endcase
  endfunction
  // Classic single cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] din, output logic [31:0] dout);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= din;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    dout = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // One link access; irq follows the sticky status and the mask, then clears
  task automatic op(input logic rd, input logic sel, input logic [7:0] ptr, input logic [7:0] d,
                    output logic [7:0] q, output logic nk);
    logic [31:0] r;
    wb(1'b1, `BSRP_WB_CMD, {13'h0, sel, rd, 1'b1, ptr, d}, r);
    r = 32'h0;
    // Done comes last, after any nack, so a new command is never refused as busy
    while (r[`BSRP_ST_DONE] !== 1'b1) wb(1'b0, `BSRP_WB_STAT, 32'h0, r);
    nk = r[`BSRP_ST_NACK];
    @(posedge clk_i);
    chk("irq", {31'h0, !msk_on}, {31'h0, irq_o});
    wb(1'b0, `BSRP_WB_DATA, 32'h0, r);
    q = r[7:0];
    wb(1'b1, `BSRP_WB_STAT, 32'h3, r);
    @(posedge clk_i);
    @(posedge clk_i);
    chk("irq clear", 32'h0, {31'h0, irq_o});
  endtask
  // Read a register and compare with the model
  task automatic rd_chk(input logic [7:0] p);
    logic [7:0] q;
    logic nk;
    op(1'b1, addr_sel_i, p, 8'h00, q, nk);
    chk("read nack", 32'h0, {31'h0, nk});
    chk("read data", mdl[p], {24'h0, q});
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [7:0] v, q;
    logic [31:0] r;
    logic nk;
    foreach (mdl[i]) mdl[i] = 0;
    mdl[0] = 8'hFF;
    mdl[7] = 8'h60;
    mdl[3] = `BSRP_IDENT_VAL;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, `BSRP_WB_MASK, 32'h3, r);
    // Reset values at the ports and over the link
    chk("fault pin", 32'h1, {31'h0, fault_n_o});
    chk("nv port", 32'h0, {24'h0, o_nv});
    foreach (rw_list[i]) chk("reset port", mdl[rw_list[i]], {24'h0, port_of(rw_list[i])});
    foreach (rw_list[i]) rd_chk(rw_list[i]);
    $display("test reset done");
    // Random writes to every writable register except nvctl, then read back
    foreach (rw_list[i]) begin
      rnd(v);
      op(1'b0, 1'b0, rw_list[i], v, q, nk);
      chk("write nack", 32'h0, {31'h0, nk});
      mdl[rw_list[i]] = v;
      chk("write port", mdl[rw_list[i]], {24'h0, port_of(rw_list[i])});
      rd_chk(rw_list[i]);
    end
    $display("test write done");
    // Read-only and unmapped places ignore writes; masked completion raises no irq
    msk_on = 1'b1;
    wb(1'b1, `BSRP_WB_MASK, 32'h0, r);
    rnd(v);
    ll_hi <= v;
    mdl[8'h0A] = v;
    rnd(v);
    ll_lo <= v;
    mdl[8'h0B] = v;
    rnd(v);
    t_hi <= v;
    mdl[8'h0D] = v;
    rnd(v);
    t_lo <= v;
    mdl[8'h0E] = v;
    foreach (rw_list[i]) begin
      v = (i < 6) ? {5'h0, i[2:0]} : 8'h20;
      v = (v == 8'h00) ? 8'h03 : (v < 8'h05) ? 8'h09 + v : (v == 8'h05) ? 8'h0E : v;
      rnd(q);
      op(1'b0, 1'b0, v, q, q, nk);
      rd_chk(v);
    end
    $display("test read only done");
    // Address-select pin picks which of the two addresses answers
    addr_sel_i <= 1'b1;
    op(1'b0, 1'b0, 8'h00, 8'h5A, q, nk);
    chk("wrong address", 32'h1, {31'h0, nk});
    chk("unchanged", mdl[0], {24'h0, o_pb});
    op(1'b0, 1'b1, 8'h00, 8'h3C, q, nk);
    chk("alt address", 32'h0, {31'h0, nk});
    mdl[0] = 8'h3C;
    rd_chk(8'h00);
    addr_sel_i <= 1'b0;
    op(1'b1, 1'b1, 8'h00, 8'h00, q, nk);
    chk("wrong address", 32'h1, {31'h0, nk});
    $display("test address done");
    // Fault events: sticky flags, cleared by reading, pin released by status read
    @(posedge clk_i);
    fault_evt_i <= 8'h04;
    @(posedge clk_i);
    fault_evt_i <= 8'h00;
    repeat (6) @(posedge clk_i);
    chk("fault pin low", 32'h0, {31'h0, fault_n_o});
    mdl[2] = 8'h04;
    rd_chk(8'h02);
    mdl[2] = 8'h00;
    rd_chk(8'h02);
    chk("fault pin high", 32'h1, {31'h0, fault_n_o});
    led_fault_evt_i <= 8'h20;
    @(posedge clk_i);
    led_fault_evt_i <= 8'h00;
    mdl[8'h0C] = 8'h20;
    rd_chk(8'h0C);
    mdl[8'h0C] = 8'h00;
    rd_chk(8'h0C);
    $display("test fault done");
    tally_and_finish();
  end
endmodule // bsrp_tb
`default_nettype wire
